/* File: pkg/tscd_defs.svh */
// constants and encodings for the transceiver strap decoder
`ifndef TSCD_DEFS_SVH
`define TSCD_DEFS_SVH

`define TSCD_RATE_FULL    3'h0
`define TSCD_RATE_HALF    3'h1
`define TSCD_RATE_QUARTER 3'h2
`define TSCD_RATE_EIGHTH  3'h3
`define TSCD_RATE_SW      3'h4
`define TSCD_RATE_SENSE   3'h5
`define TSCD_RATE_SENSE_M 3'h6
`define TSCD_RATE_SLAVE   3'h7

`define TSCD_PA_HI        4
`define TSCD_PA_LO        1
`define TSCD_PA_CHAN      0
`define TSCD_CHAN_A       1'h0
`define TSCD_CHAN_B       1'h1

`define TSCD_SETTLE_LAST  2'h3
`define TSCD_SPEED_W      2
`define TSCD_STRAP_W      13

`endif

/* File: pkg/tscd_pkg.sv */
// types shared by the strap decoder modules
package tscd_pkg;

  typedef struct packed {
    logic [4:0] portAddr;
    logic       refPick;
    logic [2:0] rateA;
    logic [2:0] rateB;
    logic       clkOutSel;
  } tscd_strap_t;

  typedef enum logic [0:0] {
    TSCD_SETTLE = 1'b0,
    TSCD_RUN    = 1'b1
  } tscd_phase_t;

endpackage

/* File: pkg/tscd_sync_if.sv */
// strap levels before and after the two-stage synchroniser
`timescale 1ns/100ps
interface tscd_sync_if;
  import tscd_pkg::*;
  tscd_strap_t rawStrap;
  tscd_strap_t syncStrap;
  modport producer (input rawStrap, output syncStrap);
  modport consumer (output rawStrap, input syncStrap);
endinterface // tscd_sync_if

/* File: rtl/tscd_strap_sync.sv */
// two flip-flop synchroniser for the strap pins
`timescale 1ns/100ps
module tscd_strap_sync (
  input  wire logic   clk,
  input  wire logic   srst,
  tscd_sync_if.producer sync
);
  import tscd_pkg::*;

  typedef struct packed {
    tscd_strap_t stage1;
    tscd_strap_t stage2;
  } tscd_sync_state_t;

  tscd_sync_state_t state_q;
  tscd_sync_state_t state_d;

  always_comb begin
    state_d        = state_q;
    state_d.stage1 = sync.rawStrap;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync.syncStrap = state_q.stage2;
endmodule // tscd_strap_sync

/* File: rtl/tscd_top.sv */
// strap decoder: address match, reference clock pick, channel A rate mode
`timescale 1ns/100ps
`include "tscd_defs.svh"
module tscd_top (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [4:0] portAddressStrap,
  input  wire logic       chanARefclkPick,
  input  wire logic [2:0] rateAStrap,
  input  wire logic [2:0] rateBStrap,
  input  wire logic       clkOutSelPin,
  input  wire logic       swRefclkPick,
  input  wire logic       swClkOutSel,
  input  wire logic [1:0] swRate,
  input  wire logic [1:0] chanARegRate,
  input  wire logic [1:0] chanASenseRate,
  input  wire logic [1:0] chanBSenseRate,
  input  wire logic       phyAddrValid,
  input  wire logic [4:0] inbandPhyAddressField,
  output logic            strapsReady,
  output logic            mgmtRespond,
  output logic            mgmtChanB,
  output logic            refClockOneSel,
  output logic [1:0]      chanARate,
  output logic            chanASwRate,
  output logic            chanASenseOn,
  output logic            chanAFollowB,
  output logic            clkOutSelApplies,
  output logic            clkOutFromChanB,
  output logic            strapConflict
);
  import tscd_pkg::*;

  typedef struct packed {
    tscd_phase_t phase;
    logic [1:0]  settleCnt;
    tscd_strap_t held;
    logic        respond;
    logic        chanB;
    logic        refOne;
    logic [1:0]  rate;
    logic        swMode;
    logic        senseOn;
    logic        followB;
    logic        selApplies;
    logic        outB;
    logic        conflict;
  } tscd_state_t;

  tscd_state_t state_q;
  tscd_state_t state_d;
  tscd_sync_if strapBus ();

  assign strapBus.rawStrap = '{portAddr:  portAddressStrap,
                               refPick:   chanARefclkPick,
                               rateA:     rateAStrap,
                               rateB:     rateBStrap,
                               clkOutSel: clkOutSelPin};

  tscd_strap_sync u_sync (
    .clk  (clk),
    .srst (srst),
    .sync (strapBus.producer)
  );

  // decoded views of the captured straps
  logic bSensing;
  logic aSenseMaster;
  logic bSenseMaster;
  logic bothSlave;
  logic bothMaster;
  logic strapBitZero;
  logic addrMatch;
  logic selPick;

  always_comb begin
    state_d = state_q;
    // straps only settle after reset; capture once, then hold as static
    case (state_q.phase)
      TSCD_SETTLE: begin
        state_d.settleCnt = state_q.settleCnt + 2'h1;
        if (state_q.settleCnt == `TSCD_SETTLE_LAST) begin
          state_d.held  = strapBus.syncStrap;
          state_d.phase = TSCD_RUN;
        end else begin
          state_d.phase = TSCD_SETTLE;
        end
      end
      TSCD_RUN: begin
        state_d.phase = TSCD_RUN;
      end
      default: begin
        state_d.phase = TSCD_SETTLE;
      end
    endcase

    bSensing     = (state_q.held.rateB == `TSCD_RATE_SENSE) ||
                   (state_q.held.rateB == `TSCD_RATE_SENSE_M);
    aSenseMaster = (state_q.held.rateA == `TSCD_RATE_SENSE_M);
    bSenseMaster = (state_q.held.rateB == `TSCD_RATE_SENSE_M);
    bothSlave    = (state_q.held.rateA == `TSCD_RATE_SLAVE) &&
                   (state_q.held.rateB == `TSCD_RATE_SLAVE);
    bothMaster   = aSenseMaster && bSenseMaster;
    strapBitZero = state_q.held.portAddr[`TSCD_PA_CHAN];
    // software bit ORed with pin; pin is held low when software picks
    selPick      = state_q.held.clkOutSel | swClkOutSel;
    // strap bit 0 deliberately left out of the compare
    addrMatch    = (inbandPhyAddressField[`TSCD_PA_HI:`TSCD_PA_LO] ==
                    state_q.held.portAddr[`TSCD_PA_HI:`TSCD_PA_LO]);

    // answer is high for each matching valid cycle once straps are captured, one cycle later; channel bit holds until next access
    if (phyAddrValid && (state_q.phase == TSCD_RUN)) begin
      state_d.respond = addrMatch;
    end else begin
      state_d.respond = 1'h0;
    end
    if (phyAddrValid) begin
      state_d.chanB = inbandPhyAddressField[`TSCD_PA_CHAN];
    end else begin
      state_d.chanB = state_q.chanB;
    end

    if (state_q.held.refPick || swRefclkPick) begin
      state_d.refOne = 1'h1;
    end else begin
      state_d.refOne = 1'h0;
    end

    // one rate value serves transmit and receive alike; a channel B
    // master sensing mode takes the output clock away from the pin
    case (state_q.held.rateA)
      `TSCD_RATE_FULL, `TSCD_RATE_HALF,
      `TSCD_RATE_QUARTER, `TSCD_RATE_EIGHTH: begin
        state_d.rate       = state_q.held.rateA[1:0];
        state_d.swMode     = 1'h0;
        state_d.senseOn    = 1'h0;
        state_d.followB    = 1'h0;
        state_d.selApplies = !bSenseMaster;
      end
      `TSCD_RATE_SW: begin
        state_d.rate       = swRate;
        state_d.swMode     = 1'h1;
        state_d.senseOn    = 1'h0;
        state_d.followB    = 1'h0;
        state_d.selApplies = !bSenseMaster;
      end
      `TSCD_RATE_SENSE: begin
        state_d.rate       = chanASenseRate;
        state_d.swMode     = 1'h0;
        state_d.senseOn    = 1'h1;
        state_d.followB    = 1'h0;
        state_d.selApplies = !bSenseMaster;
      end
      `TSCD_RATE_SENSE_M: begin
        state_d.rate       = chanASenseRate;
        state_d.swMode     = 1'h0;
        state_d.senseOn    = 1'h1;
        state_d.followB    = 1'h0;
        state_d.selApplies = 1'h0;
      end
      `TSCD_RATE_SLAVE: begin
        // channel A slaves to channel B only while channel B senses
        state_d.swMode  = 1'h0;
        state_d.senseOn = 1'h0;
        if (bSensing) begin
          state_d.rate       = chanBSenseRate;
          state_d.followB    = 1'h1;
          state_d.selApplies = 1'h0;
        end else begin
          state_d.rate       = chanARegRate;
          state_d.followB    = 1'h0;
          state_d.selApplies = 1'h1;
        end
      end
      default: begin
        state_d.rate       = state_q.held.rateA[1:0];
        state_d.swMode     = 1'h0;
        state_d.senseOn    = 1'h0;
        state_d.followB    = 1'h0;
        state_d.selApplies = 1'h1;
      end
    endcase

    // output clock source; channel A in 110 wins over everything else
    if (aSenseMaster) begin
      state_d.outB = `TSCD_CHAN_A;
    end else if (bSenseMaster) begin
      state_d.outB = `TSCD_CHAN_B;
    end else if (state_d.followB) begin
      state_d.outB = `TSCD_CHAN_B;
    end else begin
      state_d.outB = selPick;
    end

    // flags strap combinations the board is forbidden to use
    if ((state_q.phase == TSCD_RUN) &&
        (bothSlave || bothMaster || strapBitZero)) begin
      state_d.conflict = 1'h1;
    end else begin
      state_d.conflict = 1'h0;
    end
  end

  // reset clears the captured straps so every reset captures them anew
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // every output comes straight from a state flop
  assign strapsReady      = (state_q.phase == TSCD_RUN);
  assign mgmtRespond      = state_q.respond;
  assign mgmtChanB        = state_q.chanB;
  assign refClockOneSel   = state_q.refOne;
  assign chanARate        = state_q.rate;
  assign chanASwRate      = state_q.swMode;
  assign chanASenseOn     = state_q.senseOn;
  assign chanAFollowB     = state_q.followB;
  assign clkOutSelApplies = state_q.selApplies;
  assign clkOutFromChanB  = state_q.outB;
  assign strapConflict    = state_q.conflict;
endmodule // tscd_top

/* File: test/tscd_chk.sv */
// assertions on the strap decoder ports
`timescale 1ns/100ps
module tscd_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [4:0] portAddressStrap,
  input wire logic       chanARefclkPick,
  input wire logic [2:0] rateAStrap,
  input wire logic [2:0] rateBStrap,
  input wire logic       clkOutSelPin,
  input wire logic       swRefclkPick,
  input wire logic       swClkOutSel,
  input wire logic [1:0] swRate,
  input wire logic [1:0] chanARegRate,
  input wire logic [1:0] chanASenseRate,
  input wire logic [1:0] chanBSenseRate,
  input wire logic       phyAddrValid,
  input wire logic [4:0] inbandPhyAddressField,
  input wire logic       strapsReady,
  input wire logic       mgmtRespond,
  input wire logic       mgmtChanB,
  input wire logic       refClockOneSel,
  input wire logic [1:0] chanARate,
  input wire logic       chanASwRate,
  input wire logic       chanASenseOn,
  input wire logic       chanAFollowB,
  input wire logic       clkOutSelApplies,
  input wire logic       clkOutFromChanB
);
  logic go, hit, bSense, slave;
  assign go = strapsReady && phyAddrValid;
  assign hit = inbandPhyAddressField[4:1] == portAddressStrap[4:1];
  assign bSense = rateBStrap inside {3'h5, 3'h6};
  assign slave = strapsReady && rateAStrap == 3'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RESP: assert property (go |=> mgmtRespond == $past(hit))
    else $error("address answer wrong");
  AST_CHAN: assert property (go |=> mgmtChanB == $past(inbandPhyAddressField[0]))
    else $error("channel pick wrong");
  AST_REF: assert property (strapsReady |=>
    refClockOneSel == $past(chanARefclkPick | swRefclkPick))
    else $error("reference clock pick wrong");
  AST_FIXED: assert property (strapsReady && !rateAStrap[2] |=>
    chanARate == rateAStrap[1:0] && !chanASwRate && !chanASenseOn)
    else $error("fixed rate wrong");
  AST_SOFT: assert property (strapsReady && rateAStrap == 3'h4 |=>
    chanASwRate && chanARate == $past(swRate))
    else $error("software rate wrong");
  AST_SENSE: assert property (strapsReady && rateBStrap != 3'h6 &&
    rateAStrap inside {3'h5, 3'h6} |=> chanASenseOn &&
    chanARate == $past(chanASenseRate) &&
    clkOutSelApplies == rateAStrap[0]) else $error("sensing mode wrong");
  AST_FOLLOW: assert property (slave && bSense |=> chanAFollowB &&
    !clkOutSelApplies && chanARate == $past(chanBSenseRate))
    else $error("slave follow wrong");
  AST_OWNREG: assert property (slave && !bSense |=> !chanAFollowB &&
    clkOutSelApplies && chanARate == $past(chanARegRate))
    else $error("slave register rate wrong");
  AST_OUTCLK: assert property (strapsReady && rateAStrap < 3'h5 &&
    rateBStrap != 3'h6 |=> clkOutFromChanB == $past(clkOutSelPin | swClkOutSel))
    else $error("output clock source wrong");
endmodule // tscd_chk
bind tscd_top tscd_chk u_chk (
  .clk                   (clk),
  .srst                  (srst),
  .portAddressStrap      (portAddressStrap),
  .chanARefclkPick       (chanARefclkPick),
  .rateAStrap            (rateAStrap),
  .rateBStrap            (rateBStrap),
  .clkOutSelPin          (clkOutSelPin),
  .swRefclkPick          (swRefclkPick),
  .swClkOutSel           (swClkOutSel),
  .swRate                (swRate),
  .chanARegRate          (chanARegRate),
  .chanASenseRate        (chanASenseRate),
  .chanBSenseRate        (chanBSenseRate),
  .phyAddrValid          (phyAddrValid),
  .inbandPhyAddressField (inbandPhyAddressField),
  .strapsReady           (strapsReady),
  .mgmtRespond           (mgmtRespond),
  .mgmtChanB             (mgmtChanB),
  .refClockOneSel        (refClockOneSel),
  .chanARate             (chanARate),
  .chanASwRate           (chanASwRate),
  .chanASenseOn          (chanASenseOn),
  .chanAFollowB          (chanAFollowB),
  .clkOutSelApplies      (clkOutSelApplies),
  .clkOutFromChanB       (clkOutFromChanB)
);

/* File: test/tscd_board_model.sv */
// board strap drivers for the port address pins
`timescale 1ns/100ps
module tscd_board_model (
  input wire logic [3:0] addrHi,
  output logic     [4:0] portAddressStrap
);
  assign portAddressStrap = {addrHi, 1'h0};
endmodule // tscd_board_model

/* File: test/tb.sv */
// testbench for the strap decoder
`timescale 1ns/100ps
module tb;
  logic clk = 1'h0, srst = 1'h1, chanARefclkPick = 1'h0, clkOutSelPin = 1'h0;
  logic swRefclkPick = 1'h0, swClkOutSel = 1'h0, phyAddrValid = 1'h0;
  logic [2:0] rateAStrap = 3'h0, rateBStrap = 3'h0, a, b;
  logic [1:0] swRate = 2'h0, chanARegRate = 2'h0, chanASenseRate = 2'h0;
  logic [1:0] chanBSenseRate = 2'h0, chanARate, er;
  logic [4:0] inbandPhyAddressField = 5'h00, portAddressStrap;
  logic [3:0] addrHi = 4'h0;
  logic strapsReady, mgmtRespond, mgmtChanB, refClockOneSel, chanASwRate;
  logic chanASenseOn, chanAFollowB, clkOutSelApplies, clkOutFromChanB;
  logic strapConflict, bs;
  logic [2:0] aT [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
                          3'h5, 3'h6, 3'h7, 3'h7, 3'h1};
  logic [2:0] bT [10] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h5,
                          3'h5, 3'h5, 3'h5, 3'h0, 3'h6};
  int n_fail = 0, checked = 0, n;
  tscd_top dut (
    .clk                   (clk),
    .srst                  (srst),
    .portAddressStrap      (portAddressStrap),
    .chanARefclkPick       (chanARefclkPick),
    .rateAStrap            (rateAStrap),
    .rateBStrap            (rateBStrap),
    .clkOutSelPin          (clkOutSelPin),
    .swRefclkPick          (swRefclkPick),
    .swClkOutSel           (swClkOutSel),
    .swRate                (swRate),
    .chanARegRate          (chanARegRate),
    .chanASenseRate        (chanASenseRate),
    .chanBSenseRate        (chanBSenseRate),
    .phyAddrValid          (phyAddrValid),
    .inbandPhyAddressField (inbandPhyAddressField),
    .strapsReady           (strapsReady),
    .mgmtRespond           (mgmtRespond),
    .mgmtChanB             (mgmtChanB),
    .refClockOneSel        (refClockOneSel),
    .chanARate             (chanARate),
    .chanASwRate           (chanASwRate),
    .chanASenseOn          (chanASenseOn),
    .chanAFollowB          (chanAFollowB),
    .clkOutSelApplies      (clkOutSelApplies),
    .clkOutFromChanB       (clkOutFromChanB),
    .strapConflict         (strapConflict)
  );
  tscd_board_model board (
    .addrHi           (addrHi),
    .portAddressStrap (portAddressStrap)
  );
  always #50 clk = ~clk;
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 10; i++) begin
      a = aT[i];
      b = bT[i];
      bs = b[2] & (b[1] ^ b[0]);
      srst = 1'h1;
      addrHi = 4'(i + 3);
      rateAStrap = a;
      rateBStrap = b;
      chanARefclkPick = a[0];
      swRefclkPick = (a == 3'h4);
      clkOutSelPin = a[1];
      swClkOutSel = (a == 3'h1);
      swRate = 2'(i + 2);
      chanARegRate = 2'(i + 1);
      chanBSenseRate = 2'(i + 3);
      chanASenseRate = 2'(i);
      repeat (3) step;
      srst = 1'h0;
      for (n = 0; n < 20 && strapsReady !== 1'h1; n++) step;
      if (n == 20) begin
        n_fail++;
        end_sim;
      end
      phyAddrValid = 1'h1;
      inbandPhyAddressField = {addrHi, 1'h1};
      step;
      chk(mgmtRespond, 1'h1);
      chk(mgmtChanB, 1'h1);
      inbandPhyAddressField = {~addrHi, 1'h0};
      step;
      chk(mgmtRespond, 1'h0);
      chk(mgmtChanB, 1'h0);
      phyAddrValid = 1'h0;
      step;
      chk(strapConflict, 1'h0);
      chk(refClockOneSel, a[0] | (a == 3'h4));
      chk(chanASwRate, a == 3'h4);
      chk(chanASenseOn, a == 3'h5 || a == 3'h6);
      chk(chanAFollowB, a == 3'h7 && bs);
      chk(clkOutSelApplies,
          !(a == 3'h6 || (a == 3'h7 && bs) || b == 3'h6));
      chk(clkOutFromChanB, a == 3'h6 ? 1'h0 : (b == 3'h6 || (a == 3'h7 && bs))
        ? 1'h1 : a[1] | (a == 3'h1));
      er = !a[2] ? a[1:0] : a == 3'h4 ? swRate :
           a[1] ^ a[0] ? chanASenseRate : bs ? chanBSenseRate : chanARegRate;
      chk(chanARate, er);
    end
    end_sim;
  end
endmodule // tb
